/* File: hw/pdn_pkg.sv */
package pdn_pkg;

    // Dictionary address space
    localparam int unsigned INDEX_W = 16;
    localparam int unsigned SUB_W   = 8;
    localparam int unsigned DATA_W  = 32;

    // Area bases
    localparam logic [15:0] IDENT_BASE    = 16'h1000;
    localparam logic [15:0] LEGACY_BASE   = 16'h4000;
    localparam logic [15:0] INPUT_BASE    = 16'h6000;
    localparam logic [15:0] OUTPUT_BASE   = 16'h7000;
    localparam logic [15:0] CHAN_BASE     = 16'h8000;
    localparam logic [15:0] CHAN_STEP     = 16'h0010;
    localparam logic [15:0] VOLATILE_IDX  = 16'hf008;
    localparam logic [31:0] VOLATILE_CODE = 32'h1234_5678;

    // Identity entries at 0x1000 area, subindex positions
    localparam logic [15:0] IDENT_NAME_IDX   = 16'h1008;
    localparam logic [15:0] IDENT_MAKER_IDX  = 16'h1018;
    localparam logic [7:0]  IDENT_MAKER_SUB  = 8'h01;
    localparam logic [7:0]  IDENT_SERIAL_SUB = 8'h04;
    localparam logic [15:0] IDENT_PDCFG_IDX  = 16'h1c00;

    // Reset values
    localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
    localparam logic [31:0] CODE_RESET  = 32'h0000_0000;
    localparam logic [63:0] TIME_RESET  = 64'h0;

    // Time base: 1 ns units on a 100 ns clock
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TIME_UNIT_NS  = 1;
    localparam int unsigned TIME_STEP     = CLK_PERIOD_NS / TIME_UNIT_NS;

    // Nonvolatile commit latency in cycles
    localparam int unsigned NV_BUSY_CYCLES = 8;

    // Abort codes
    localparam logic [31:0] ABORT_NONE     = 32'h0000_0000;
    localparam logic [31:0] ABORT_NO_ENTRY = 32'h0602_0000;
    localparam logic [31:0] ABORT_NO_SUB   = 32'h0609_0011;
    localparam logic [31:0] ABORT_READONLY = 32'h0601_0002;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } pdn_req_type;

    typedef struct packed {
        logic        valid;
        logic        abort;
        logic [31:0] code;
        logic [31:0] rdata;
    } pdn_rsp_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] data;
    } pdn_nv_type;

    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_RO,
        ACC_RW
    } pdn_access_type;

endpackage : pdn_pkg

/* File: hw/pdn_dictionary.sv */
module pdn_dictionary #(
    parameter int unsigned CHANNELS   = 2,
    parameter int unsigned SUBS       = 8,
    parameter bit          TIME_32BIT = 1'b0,
    parameter logic [31:0] SERIAL_NO  = 32'h0000_0001, // Arbitrary value
    parameter logic [31:0] MAKER_ID   = 32'h0000_00aa, // Arbitrary value
    parameter logic [31:0] NAME_WORD  = 32'h5044_4e31  // Arbitrary value
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_i,
    input  wire pdn_pkg::pdn_req_type req_i,
    input  wire logic [31:0]          in_pdo_i,
    input  wire logic                 nv_ready_i,
    input  wire logic                 time_load_i,
    input  wire logic [63:0]          time_value_i,
    output logic                      busy_o,
    output pdn_pkg::pdn_rsp_type      rsp_o,
    output pdn_pkg::pdn_nv_type       nv_o,
    output logic                      nv_write_suppress_o,
    output logic [31:0]               out_pdo_o,
    output logic [63:0]               time_o
);
    import pdn_pkg::*;

    localparam int unsigned CH_W  = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
    localparam int unsigned SUB_IW = (SUBS > 1) ? $clog2(SUBS) : 1;

    // Decoded target of one access
    typedef struct packed {
        pdn_access_type acc;
        logic           is_chan;
        logic           is_code;
        logic           is_out;
        logic [CH_W-1:0]   ch;
        logic [SUB_IW-1:0] sub;
        logic [31:0]    ro_val;
        logic           no_sub;
    } pdn_target_type;

    // Parameter storage, flip-flops indexed by channel and subindex
    logic [31:0] param_q [CHANNELS][SUBS];
    logic [31:0] code_q;
    logic [31:0] out_pdo_q;
    logic [31:0] in_pdo_s1_q;
    logic [31:0] in_pdo_q;
    logic [31:0] in_pdo_last_q;
    logic [31:0] in_pdo_hold_q;
    logic        nv_ready_s1_q;
    logic        nv_ready_q;
    logic [63:0] time_q;
    logic        volatile_q;
    pdn_rsp_type rsp_q;
    pdn_nv_type  nv_q;
    logic        busy_q;
    pdn_target_type tgt;
    logic        wr_ok;
    logic        rd_ok;

    // Map an index/subindex to an entry and its access attribute
    function automatic pdn_target_type decode(
        input logic [15:0] idx,
        input logic [7:0]  sub,
        input logic [31:0] in_val
    );
        pdn_target_type t;
        logic [15:0]    off;
        t = '0;
        off = 16'h0;
        t.acc = ACC_NONE;
        if (idx == IDENT_NAME_IDX && sub == 8'h00)
        begin
            t.acc = ACC_RO;
            t.ro_val = NAME_WORD;
        end
        else if (idx == IDENT_MAKER_IDX)
        begin
            t.acc = ACC_RO;
            if (sub == IDENT_MAKER_SUB)
                t.ro_val = MAKER_ID;
            else if (sub == IDENT_SERIAL_SUB)
                t.ro_val = SERIAL_NO;
            else if (sub == 8'h00)
                t.ro_val = 32'h0000_0004;
            else
                t.no_sub = 1'b1;
        end
        else if (idx == IDENT_PDCFG_IDX && sub == 8'h00)
        begin
            t.acc = ACC_RO;
            t.ro_val = {24'h0, 8'(CHANNELS)};
        end
        else if (idx == INPUT_BASE && sub == 8'h01)
        begin
            t.acc = ACC_RO;
            t.ro_val = in_val;
        end
        else if (idx == OUTPUT_BASE && sub == 8'h01)
        begin
            t.acc = ACC_RW;
            t.is_out = 1'b1;
        end
        else if (idx == VOLATILE_IDX && sub == 8'h00)
        begin
            t.acc = ACC_RW;
            t.is_code = 1'b1;
        end
        else if (idx[15:12] == CHAN_BASE[15:12]
                 || idx[15:12] == LEGACY_BASE[15:12])
        begin
            off = {4'h0, idx[11:0]};
            // Only the first index of each channel block holds storage
            if (off[3:0] == 4'h0 && (off >> 4) < 16'(CHANNELS)
                && sub < 8'(SUBS))
            begin
                t.acc = ACC_RW;
                t.is_chan = 1'b1;
                t.ch = CH_W'(off >> 4);
                t.sub = SUB_IW'(sub);
            end
        end
        return t;
    endfunction : decode

    // full 16/8 bit address is decoded, except that the 0x4000 area aliases the 0x8000 channel area
    assign tgt   = decode(req_i.index, req_i.sub, in_pdo_hold_q);
    assign rd_ok = req_i.valid && !req_i.write && tgt.acc != ACC_NONE
                   && !tgt.no_sub;
    // Writes are refused while a commit is in flight to keep the store consistent
    assign wr_ok = req_i.valid && req_i.write && tgt.acc == ACC_RW
                   && !busy_q;

    // Pin-level inputs pass two flops
    always_ff @(posedge ref_clk_i)
    begin
        in_pdo_s1_q   <= in_pdo_i;
        in_pdo_q      <= in_pdo_s1_q;
        nv_ready_s1_q <= nv_ready_i;
        nv_ready_q    <= nv_ready_s1_q;
    end

    // Synced word taken only once two samples agree, so a word
    // caught mid-change on the pins is never read torn
    always_ff @(posedge ref_clk_i)
    begin
        in_pdo_last_q <= in_pdo_q;
        if (in_pdo_q == in_pdo_last_q)
            in_pdo_hold_q <= in_pdo_q;
    end

    // Channel parameter store, shared by both areas
    generate
        for (genvar c = 0; c < CHANNELS; c++)
        begin : g_ch
            for (genvar s = 0; s < SUBS; s++)
            begin : g_sub
                always_ff @(posedge ref_clk_i)
                begin
                    if (reset_i)
                        param_q[c][s] <= PARAM_RESET;
                    else if (wr_ok && tgt.is_chan && tgt.ch == CH_W'(c)
                             && tgt.sub == SUB_IW'(s))
                        param_q[c][s] <= req_i.wdata;
                end
            end
        end
    endgenerate

    // Code word entry and volatile mode
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            code_q     <= CODE_RESET;
            volatile_q <= 1'b0;
        end
        else if (wr_ok && tgt.is_code)
        begin
            code_q     <= req_i.wdata;
            // Any other value disarms the mode
            volatile_q <= (req_i.wdata == VOLATILE_CODE);
        end
    end

    // Output process data word
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            out_pdo_q <= PARAM_RESET;
        else if (wr_ok && tgt.is_out)
            out_pdo_q <= req_i.wdata;
    end

    // Response to every request, one cycle later
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            rsp_q <= '0;
        else
        begin
            rsp_q.valid <= req_i.valid;
            rsp_q.abort <= 1'b0;
            rsp_q.code  <= ABORT_NONE;
            rsp_q.rdata <= 32'h0;
            if (req_i.valid && !req_i.write)
            begin
                if (!rd_ok)
                begin
                    rsp_q.abort <= 1'b1;
                    rsp_q.code  <= tgt.no_sub ? ABORT_NO_SUB
                                              : ABORT_NO_ENTRY;
                end
                else if (tgt.is_chan)
                    rsp_q.rdata <= param_q[tgt.ch][tgt.sub];
                else if (tgt.is_code)
                    rsp_q.rdata <= code_q;
                else if (tgt.is_out)
                    rsp_q.rdata <= out_pdo_q;
                else
                    rsp_q.rdata <= tgt.ro_val;
            end
            // Refused write, nothing was stored
            else if (req_i.valid && !wr_ok)
            begin
                rsp_q.abort <= 1'b1;
                if (tgt.acc == ACC_RO)
                    rsp_q.code <= ABORT_READONLY;
                else if (tgt.acc == ACC_NONE || tgt.no_sub)
                    rsp_q.code <= ABORT_NO_ENTRY;
                else
                    rsp_q.code <= ABORT_READONLY;
            end
        end
    end

    // Nonvolatile commit of changed channel parameters
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            nv_q   <= '0;
            busy_q <= 1'b0;
        end
        else if (wr_ok && tgt.is_chan && !volatile_q
                 && param_q[tgt.ch][tgt.sub] != req_i.wdata)
        begin
            nv_q.valid <= 1'b1;
            nv_q.index <= req_i.index;
            nv_q.sub   <= req_i.sub;
            nv_q.data  <= req_i.wdata;
            busy_q     <= 1'b1;
        end
        else if (nv_q.valid && nv_ready_q)
        begin
            // Hold until the store acknowledges, so no update is lost
            nv_q.valid <= 1'b0;
        end
        else if (!nv_q.valid && !nv_ready_q)
        begin
            // Stay busy until the old ack has drained from the
            // synchroniser, else the next commit would take it as its own
            busy_q <= 1'b0;
        end
    end

    // Local time counter, 1 ns units from the epoch
    // A load from the master wins over counting in that cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            time_q <= TIME_RESET;
        else if (time_load_i)
            time_q <= time_value_i;
        else if (TIME_32BIT)
            time_q <= {32'h0, time_q[31:0] + 32'(TIME_STEP)};
        else
            time_q <= time_q + 64'(TIME_STEP);
    end

    assign busy_o              = busy_q;
    assign rsp_o               = rsp_q;
    assign nv_o                = nv_q;
    assign nv_write_suppress_o = volatile_q;
    assign out_pdo_o           = out_pdo_q;
    assign time_o              = time_q;

endmodule : pdn_dictionary

/* File: dv/pdn_dictionary_monitor.sv */
module pdn_dictionary_monitor
    import pdn_pkg::*;
#(
    parameter bit TIME_32BIT = 1'b0
) (
    input wire logic                 ref_clk_i,
    input wire logic                 reset_i,
    input wire pdn_pkg::pdn_req_type req_i,
    input wire logic                 nv_ready_i,
    input wire logic                 time_load_i,
    input wire logic [63:0]          time_value_i,
    input wire logic                 busy_o,
    input wire pdn_pkg::pdn_rsp_type rsp_o,
    input wire pdn_pkg::pdn_nv_type  nv_o,
    input wire logic                 nv_write_suppress_o,
    input wire logic [31:0]          out_pdo_o,
    input wire logic [63:0]          time_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Accepted write of the code word entry
    sequence s_code_wr;
        req_i.valid && req_i.write && !busy_o &&
        req_i.index == VOLATILE_IDX && req_i.sub == 8'h00;
    endsequence
    property p_answer;
        req_i.valid |=> rsp_o.valid;
    endproperty
    a_answer: assert property (p_answer)
        else $error("request without answer");
    property p_ro;
        req_i.valid && req_i.write && req_i.index == IDENT_NAME_IDX
        |=> rsp_o.abort && rsp_o.code == ABORT_READONLY;
    endproperty
    a_ro: assert property (p_ro)
        else $error("read-only write not refused");
    property p_gone;
        req_i.valid && req_i.index == 16'h5000
        |=> rsp_o.abort && rsp_o.code == ABORT_NO_ENTRY;
    endproperty
    a_gone: assert property (p_gone)
        else $error("missing entry not refused");
    property p_arm;
        s_code_wr ##0 (req_i.wdata == VOLATILE_CODE)
        |=> nv_write_suppress_o;
    endproperty
    a_arm: assert property (p_arm)
        else $error("code word did not arm");
    property p_keep;
        nv_write_suppress_o && !req_i.valid |=> nv_write_suppress_o;
    endproperty
    a_keep: assert property (p_keep)
        else $error("volatile mode dropped");
    property p_vol;
        $rose(nv_o.valid) |-> !$past(nv_write_suppress_o);
    endproperty
    a_vol: assert property (p_vol)
        else $error("commit in volatile mode");
    property p_hold;
        $fell(nv_o.valid) |-> $past(nv_ready_i, 3) && busy_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("commit dropped early");
    property p_release;
        $fell(busy_o) |-> !nv_o.valid && !$past(nv_ready_i, 3);
    endproperty
    a_release: assert property (p_release)
        else $error("busy dropped before ready went low");
    property p_pdo;
        req_i.valid && req_i.write && !busy_o &&
        req_i.index == OUTPUT_BASE && req_i.sub == 8'h01
        |=> out_pdo_o == $past(req_i.wdata);
    endproperty
    a_pdo: assert property (p_pdo)
        else $error("output data not taken");
    property p_tick;
        !time_load_i |=> TIME_32BIT
            ? time_o == {32'h0, $past(time_o[31:0]) + 32'(TIME_STEP)}
            : time_o == $past(time_o) + 64'(TIME_STEP);
    endproperty
    a_tick: assert property (p_tick)
        else $error("time step wrong");
    property p_load;
        time_load_i |=> time_o == $past(time_value_i);
    endproperty
    a_load: assert property (p_load)
        else $error("time load wrong");
endmodule : pdn_dictionary_monitor

bind pdn_dictionary pdn_dictionary_monitor #(.TIME_32BIT(TIME_32BIT))
    u_pdn_dictionary_monitor (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i),
    .nv_ready_i(nv_ready_i), .time_load_i(time_load_i),
    .time_value_i(time_value_i), .busy_o(busy_o), .rsp_o(rsp_o),
    .nv_o(nv_o), .nv_write_suppress_o(nv_write_suppress_o),
    .out_pdo_o(out_pdo_o), .time_o(time_o));

/* File: dv/pdn_nv_model.sv */
module pdn_nv_model
    import pdn_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_i,
    input  wire pdn_pkg::pdn_nv_type  nv_i,
    input  wire logic                 slow_i,
    output logic                      nv_ready_o,
    output pdn_pkg::pdn_nv_type       stored_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_q;
    // Slow mode keeps busy up long enough to test refusals
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || !nv_i.valid)
        begin
            wait_q     <= 4'h0;
            nv_ready_o <= 1'b0;
        end
        else if (wait_q == (slow_i ? 4'hc : 4'h1))
        begin
            nv_ready_o <= 1'b1;
            stored_o   <= nv_i;
        end
        else
        begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : pdn_nv_model

/* File: dv/pdn_dictionary_test.sv */
module pdn_dictionary_test
    import pdn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] NAME  = 32'h7465_7374; // Arbitrary value
    localparam logic [31:0] SER   = 32'h0000_0123; // Arbitrary value
    localparam logic [63:0] TLOAD = 64'h0000_0000_ffff_ff9c;
    logic ref_clk_i = 1'b0, reset_i = 1'b1, slow = 1'b0, ready;
    logic time_load_i = 1'b0, busy_o, sup;
    logic [31:0] in_pdo_i = '0, out_pdo_o;
    logic [63:0] time_value_i = '0, time_o, time_w32;
    pdn_req_type req_i = '0;
    pdn_rsp_type rsp_o;
    pdn_nv_type  nv_o, stored;
    int err_count = 0, checks_done = 0, cycles = 0;
    pdn_dictionary #(.SERIAL_NO(SER), .NAME_WORD(NAME)) u_pdn_dictionary (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i),
        .in_pdo_i(in_pdo_i), .nv_ready_i(ready), .time_load_i(time_load_i),
        .time_value_i(time_value_i), .busy_o(busy_o), .rsp_o(rsp_o),
        .nv_o(nv_o), .nv_write_suppress_o(sup), .out_pdo_o(out_pdo_o),
        .time_o(time_o));
    pdn_nv_model u_pdn_nv_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .nv_i(nv_o), .slow_i(slow), .nv_ready_o(ready), .stored_o(stored));
    // Second copy in the 32-bit time variant, only its counter is used
    pdn_dictionary #(.TIME_32BIT(1'b1)) u_pdn_dictionary_w32 (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i('0),
        .in_pdo_i(32'h0), .nv_ready_i(1'b0), .time_load_i(time_load_i),
        .time_value_i(time_value_i), .busy_o(), .rsp_o(), .nv_o(),
        .nv_write_suppress_o(), .out_pdo_o(), .time_o(time_w32));
    always #50 ref_clk_i = ~ref_clk_i;
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // Hang guard, far above the hundred or so cycles needed
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            tally_and_finish;
        end
    end
    task chk(string nm, logic [63:0] exp, logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task tick;
        @(posedge ref_clk_i);
        #1;
    endtask : tick
    // One access, answer checked in the cycle it stands
    task acc(logic w, logic [15:0] ix, logic [7:0] sb, logic [31:0] d,
             logic [31:0] code, logic [31:0] rd);
        req_i = '{1'b1, w, ix, sb, d};
        tick;
        req_i.valid = 1'b0;
        chk("rsp_valid", 1, rsp_o.valid);
        chk("rsp_code", {code != ABORT_NONE, code}, {rsp_o.abort, rsp_o.code});
        if (!w && code == ABORT_NONE)
            chk("rsp_rdata", rd, rsp_o.rdata);
        tick;
    endtask : acc
    task idle;
        for (int i = 0; i < 40 && busy_o !== 1'b0; i++)
            tick;
        chk("busy_o", 0, busy_o);
    endtask : idle
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        chk("suppress", 0, sup);
        acc(0, IDENT_MAKER_IDX, 8'h00, 0, ABORT_NONE, 32'h4);
        acc(0, IDENT_MAKER_IDX, IDENT_SERIAL_SUB, 0, ABORT_NONE, SER);
        acc(1, IDENT_NAME_IDX, 8'h00, 1, ABORT_READONLY, 0);
        acc(0, IDENT_NAME_IDX, 8'h00, 0, ABORT_NONE, NAME);
        acc(0, IDENT_PDCFG_IDX, 8'h00, 0, ABORT_NONE, 32'h2);
        acc(0, 16'h5000, 8'h00, 0, ABORT_NO_ENTRY, 0);
        acc(0, IDENT_MAKER_IDX, 8'h09, 0, ABORT_NO_SUB, 0);
        acc(1, CHAN_BASE + 16'(2 * CHAN_STEP), 8'h00, 5,
            ABORT_NO_ENTRY, 0);
        acc(0, CHAN_BASE, 8'h08, 0, ABORT_NO_ENTRY, 0);
        $display("Test identity and refusals done");
        slow = 1'b1;
        acc(1, CHAN_BASE + CHAN_STEP, 8'h02, 32'hcafe_0001,
            ABORT_NONE, 0);
        chk("busy_o", 1, busy_o);
        acc(1, CHAN_BASE, 8'h07, 1, ABORT_READONLY, 0);
        idle;
        chk("nv", {CHAN_BASE + CHAN_STEP, 8'h02, 32'hcafe_0001},
            {stored.index, stored.sub, stored.data});
        acc(0, LEGACY_BASE + CHAN_STEP, 8'h02, 0,
            ABORT_NONE, 32'hcafe_0001);
        slow = 1'b0;
        acc(1, LEGACY_BASE, 8'h07, 32'h77, ABORT_NONE, 0);
        idle;
        acc(0, CHAN_BASE, 8'h07, 0, ABORT_NONE, 32'h77);
        $display("Test commit and mirror done");
        acc(1, VOLATILE_IDX, 8'h00, VOLATILE_CODE, ABORT_NONE, 0);
        chk("suppress", 1, sup);
        acc(1, CHAN_BASE, 8'h01, 32'h99, ABORT_NONE, 0);
        chk("nv_valid", 0, nv_o.valid);
        acc(0, CHAN_BASE, 8'h01, 0, ABORT_NONE, 32'h99);
        acc(0, VOLATILE_IDX, 8'h00, 0, ABORT_NONE, VOLATILE_CODE);
        acc(1, VOLATILE_IDX, 8'h00, 0, ABORT_NONE, 0);
        chk("suppress", 0, sup);
        $display("Test volatile mode done");
        acc(1, OUTPUT_BASE, 8'h01, 32'h5a5a_0f0f, ABORT_NONE, 0);
        chk("out_pdo", 32'h5a5a_0f0f, out_pdo_o);
        in_pdo_i = 32'h1357_2468;
        // Two sync stages plus two agreeing samples before it is visible
        repeat (4) tick;
        acc(0, INPUT_BASE, 8'h01, 0, ABORT_NONE, 32'h1357_2468);
        acc(1, INPUT_BASE, 8'h01, 1, ABORT_READONLY, 0);
        time_value_i = TLOAD;
        time_load_i = 1'b1;
        tick;
        time_load_i = 1'b0;
        chk("time_o", TLOAD, time_o);
        chk("time_w32", TLOAD, time_w32);
        repeat (10) tick;
        chk("time_o", TLOAD + 64'(10 * TIME_STEP), time_o);
        chk("time_w32", {32'h0, TLOAD[31:0] + 32'(10 * TIME_STEP)},
            time_w32);
        $display("Test process data and time done");
        tally_and_finish;
    end
endmodule : pdn_dictionary_test
